// ---- logic/asc_pkg.sv ----
// Package: constants and register map for the alarm setpoint comparator
package asc_pkg;
    localparam int ASC_CHANNELS = 8;
    localparam int ASC_VAL_W = 32;
    localparam int ASC_DB_W = 16;
    localparam int ASC_DLY_W = 16;
    localparam int ASC_CLK_HZ = 20_000_000;
    localparam int ASC_TICK_MS = 100;
    localparam int ASC_TICK_CYC = ASC_CLK_HZ / 1000 * ASC_TICK_MS;
    localparam int ASC_CNT_W = 21;
    localparam logic [15:0] ASC_DB_MAX = 16'hD8EF;
    localparam logic [15:0] ASC_DB_RST = 16'h000A;
    localparam logic [15:0] ASC_DLY_RST = 16'h0000;
    localparam logic [31:0] ASC_ZERO = 32'h0000_0000;
    // Global register byte offsets
    localparam logic [11:0] ASC_A_STATUS = 12'h000;
    localparam logic [11:0] ASC_A_MASK = 12'h004;
    localparam logic [11:0] ASC_A_ALARM = 12'h008;
    localparam logic [11:0] ASC_A_ACK = 12'h00C;
    localparam logic [11:0] ASC_A_VALUE = 12'h010;
    // Per-channel blocks: base + 0x20 * channel
    localparam logic [11:0] ASC_A_CH_BASE = 12'h100;
    localparam int ASC_CH_SHIFT = 5;
    localparam logic [2:0] ASC_R_HI = 3'h0;
    localparam logic [2:0] ASC_R_LO = 3'h1;
    localparam logic [2:0] ASC_R_EN = 3'h2;
    localparam logic [2:0] ASC_R_DB = 3'h3;
    localparam logic [2:0] ASC_R_DLY = 3'h4;
    localparam int ASC_EN_HI = 0;
    localparam int ASC_EN_LO = 1;
    localparam logic [1:0] ASC_RESP_OK = 2'h0;
    localparam logic [1:0] ASC_RESP_ERR = 2'h2;
endpackage

// ---- logic/asc_tick.sv ----
// Tenth-second tick generator from the system clock
`timescale 1ns/1ns
module asc_tick
    import asc_pkg::*;
#(
    parameter int TICK_CYC = ASC_TICK_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Tick out
    output logic tick
);
    logic [ASC_CNT_W-1:0] cnt_r;
    wire last = (cnt_r == ASC_CNT_W'(TICK_CYC - 1));

    // Free-running divider
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cnt_r <= '0;
            tick <= 1'b0;
        end else begin
            cnt_r <= last ? '0 : cnt_r + 1'b1;
            tick <= last;
        end
    end
endmodule // asc_tick

// ---- logic/asc_chan.sv ----
// One alarm channel: compare, deadband, trip delay, annunciator
`timescale 1ns/1ns
module asc_chan
    import asc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Sample and timing
    input wire logic signed [ASC_VAL_W-1:0] value,
    input wire logic sample,
    input wire logic tick,
    input wire logic ack,
    // Configuration
    input wire logic signed [ASC_VAL_W-1:0] hi,
    input wire logic signed [ASC_VAL_W-1:0] lo,
    input wire logic hi_en,
    input wire logic lo_en,
    input wire logic [ASC_DB_W-1:0] db,
    input wire logic [ASC_DLY_W-1:0] dly,
    // Status
    output logic alarm,
    output logic acked,
    output logic cond,
    output logic trip_ev
);
    logic [ASC_DLY_W-1:0] tcnt_r;
    // Widened to avoid overflow on threshold -/+ deadband
    wire signed [ASC_VAL_W:0] v = {value[ASC_VAL_W-1], value};
    wire signed [ASC_VAL_W:0] h = {hi[ASC_VAL_W-1], hi};
    wire signed [ASC_VAL_W:0] l = {lo[ASC_VAL_W-1], lo};
    wire signed [ASC_VAL_W:0] d = {1'b0, {(ASC_VAL_W-ASC_DB_W){1'b0}}, db};
    wire trip_hi = hi_en && (v >= h); // [RULE1] [RULE3]
    wire trip_lo = lo_en && (v <= l); // [RULE2] [RULE3]
    wire hold_hi = hi_en && (v >= h - d); // [RULE6] [RULE7]
    wire hold_lo = lo_en && (v <= l + d); // [RULE6] [RULE8]
    wire overlap = hi_en && lo_en && (h < l);
    // Inside band when overlapped, else either limit
    wire trip = overlap ? (trip_hi && trip_lo) // [RULE4] [RULE5]
                        : (trip_hi || trip_lo);
    wire held = overlap ? (hold_hi && hold_lo) : (hold_hi || hold_lo);
    wire cond_nxt = alarm ? held : trip;
    wire expired = (tcnt_r >= dly);

    // Condition register, updated on each sample
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cond <= 1'b0;
        end else if (sample) begin
            cond <= cond_nxt; // [RULE15]
        end
    end

    // Trip timer; restarts whenever the condition drops
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            tcnt_r <= '0;
        end else if (!cond) begin
            tcnt_r <= '0; // [RULE11]
        end else if (tick && !expired) begin
            tcnt_r <= tcnt_r + 1'b1; // [RULE9] [RULE15]
        end
    end

    // Alarm and acknowledge state
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            alarm <= 1'b0;
            acked <= 1'b0;
            trip_ev <= 1'b0;
        end else begin
            trip_ev <= cond && expired && !alarm;
            if (!cond) begin
                alarm <= 1'b0;
                acked <= 1'b0;
            end else if (expired) begin
                alarm <= 1'b1; // [RULE10]
                if (alarm && ack) begin
                    acked <= 1'b1; // [RULE13]
                end
            end
        end
    end
endmodule // asc_chan

// ---- logic/asc_top.sv ----
// Top: eight alarm channels with an AXI4-Lite register slave
// What this block does
// RULE1: Alarm when value at or above maximum
// RULE2: Alarm when value at or below minimum
// RULE3: Thresholds default off; off never alarms
// RULE4: Both enabled: alarm outside the band
// RULE5: Maximum below minimum: alarm inside band
// RULE6: Per-channel deadband 0..55535, default 10
// RULE7: Maximum alarm clears below threshold minus deadband
// RULE8: Minimum alarm clears above threshold plus deadband
// RULE9: Per-channel trip delay in tenths, default 0
// RULE10: Alarm only after condition held full delay
// RULE11: Condition loss restarts the delay timer
// RULE12: Annunciator flashes on entering alarm
// RULE13: Acknowledge makes annunciator steady until clear
// RULE14: Eight independent alarm channels
// RULE15: Tenth-second tick; compare on each sample
// RULE16: Source holds signed value stable with strobe
`timescale 1ns/1ns
module asc_top
    import asc_pkg::*;
#(
    parameter int NCH = ASC_CHANNELS,
    parameter int TICK_CYC = ASC_TICK_CYC,
    parameter int FLASH_TICKS = 5
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Display value sample
    input wire logic [ASC_VAL_W-1:0] disp_value,
    input wire logic disp_valid,
    // Acknowledge sources
    input wire logic ack_button,
    input wire logic ack_remote,
    // Outputs to relays and lamps
    output logic [NCH-1:0] relay_req,
    output logic [NCH-1:0] lamp_on,
    output logic irq,
    // AXI4-Lite write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // Byte-lane merge of a write into an old word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Decode a byte address into a valid flag and register
    function automatic logic [4:0] chdec(input logic [11:0] a);
        logic [11:0] off;
        logic ok;
        off = a - ASC_A_CH_BASE;
        ok = (a >= ASC_A_CH_BASE) && (off[11:ASC_CH_SHIFT] < 12'(NCH))
             && (off[4:2] <= ASC_R_DLY) && (off[1:0] == 2'h0);
        return {ok, off[4:2], 1'b0} | {4'h0, 1'b0};
    endfunction

    // Configuration storage
    logic signed [ASC_VAL_W-1:0] hi_r [NCH];
    logic signed [ASC_VAL_W-1:0] lo_r [NCH];
    logic [1:0] en_r [NCH];
    logic [ASC_DB_W-1:0] db_r [NCH];
    logic [ASC_DLY_W-1:0] dly_r [NCH];
    logic [NCH-1:0] status_r, mask_r;
    logic [ASC_VAL_W-1:0] value_r;
    logic [NCH-1:0] alarm, acked, cond, trip_ev;
    logic tick;
    logic [7:0] fcnt_r;
    logic flash_r;

    // Write channel latches: address and data in either order
    logic aw_full_r, w_full_r;
    logic [11:0] aw_r;
    logic [31:0] wd_r;
    logic [3:0] ws_r;
    wire do_wr = aw_full_r && w_full_r && !s_axi_bvalid;
    wire [4:0] wdec = chdec(aw_r);
    wire [11:0] woff = aw_r - ASC_A_CH_BASE;
    wire [2:0] wch = woff[ASC_CH_SHIFT+2:ASC_CH_SHIFT];
    wire wch_ok = wdec[4];
    wire [2:0] wreg = wdec[3:1];
    wire wr_glob = (aw_r == ASC_A_STATUS) || (aw_r == ASC_A_MASK)
                   || (aw_r == ASC_A_ALARM) || (aw_r == ASC_A_ACK)
                   || (aw_r == ASC_A_VALUE);
    wire wr_ack = do_wr && (aw_r == ASC_A_ACK) && ws_r[0] && wd_r[0];
    wire [NCH-1:0] w1c = (do_wr && aw_r == ASC_A_STATUS) ?
                         (wd_r[NCH-1:0] & {NCH{ws_r[0]}}) : '0;
    wire ack_any = ack_button || ack_remote || wr_ack;

    // AXI write handshake
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            aw_r <= '0;
            wd_r <= '0;
            ws_r <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ASC_RESP_OK;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_r <= 1'b1;
                s_axi_awready <= 1'b0;
                aw_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_r <= 1'b1;
                s_axi_wready <= 1'b0;
                wd_r <= s_axi_wdata;
                ws_r <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_full_r <= 1'b0;
                w_full_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_glob || wch_ok) ? ASC_RESP_OK
                                                   : ASC_RESP_ERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1; // Next write only after response
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Byte-lane merged words for the addressed registers
    wire [31:0] mask_m = merge(32'(mask_r), wd_r, ws_r);
    wire [31:0] en_m = merge(32'(en_r[wch]), wd_r, ws_r);
    wire [31:0] db_m = merge(32'(db_r[wch]), wd_r, ws_r);
    wire [31:0] dly_m = merge(32'(dly_r[wch]), wd_r, ws_r);

    // Channel configuration writes; thresholds reset to off
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            for (int i = 0; i < NCH; i++) begin
                hi_r[i] <= '0;
                lo_r[i] <= '0;
                en_r[i] <= 2'b00; // [RULE3]
                db_r[i] <= ASC_DB_RST; // [RULE6]
                dly_r[i] <= ASC_DLY_RST; // [RULE9]
            end
            mask_r <= '0;
        end else if (do_wr) begin
            if (aw_r == ASC_A_MASK) begin
                mask_r <= mask_m[NCH-1:0];
            end
            if (wch_ok) begin
                unique case (wreg)
                    ASC_R_HI: hi_r[wch] <= merge(hi_r[wch], wd_r, ws_r);
                    ASC_R_LO: lo_r[wch] <= merge(lo_r[wch], wd_r, ws_r);
                    ASC_R_EN: en_r[wch] <= en_m[1:0];
                    ASC_R_DB: begin
                        // Clamp deadband to its legal ceiling
                        db_r[wch] <= (db_m > 32'(ASC_DB_MAX)) ? ASC_DB_MAX
                                     : db_m[ASC_DB_W-1:0]; // [RULE6]
                    end
                    ASC_R_DLY: dly_r[wch] <= dly_m[ASC_DLY_W-1:0];
                    default: ;
                endcase
            end
        end
    end

    // Read path: one-cycle registered answer
    logic [31:0] rd_nxt;
    wire [4:0] rdec = chdec(s_axi_araddr);
    wire [11:0] roff = s_axi_araddr - ASC_A_CH_BASE;
    wire [2:0] rch = roff[ASC_CH_SHIFT+2:ASC_CH_SHIFT];
    wire rd_glob = (s_axi_araddr == ASC_A_STATUS)
                   || (s_axi_araddr == ASC_A_MASK)
                   || (s_axi_araddr == ASC_A_ALARM)
                   || (s_axi_araddr == ASC_A_ACK)
                   || (s_axi_araddr == ASC_A_VALUE);
    always_comb begin
        rd_nxt = ASC_ZERO;
        if (s_axi_araddr == ASC_A_STATUS) rd_nxt = 32'(status_r);
        if (s_axi_araddr == ASC_A_MASK) rd_nxt = 32'(mask_r);
        if (s_axi_araddr == ASC_A_ALARM) rd_nxt = {16'h0000,
            8'(acked), 8'(alarm)};
        if (s_axi_araddr == ASC_A_VALUE) rd_nxt = value_r;
        if (rdec[4]) begin
            unique case (rdec[3:1])
                ASC_R_HI: rd_nxt = hi_r[rch];
                ASC_R_LO: rd_nxt = lo_r[rch];
                ASC_R_EN: rd_nxt = 32'(en_r[rch]);
                ASC_R_DB: rd_nxt = 32'(db_r[rch]);
                ASC_R_DLY: rd_nxt = 32'(dly_r[rch]);
                default: rd_nxt = ASC_ZERO;
            endcase
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= ASC_RESP_OK;
            s_axi_arready <= 1'b1;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_arready <= 1'b0;
            s_axi_rdata <= rd_nxt;
            s_axi_rresp <= (rd_glob || rdec[4]) ? ASC_RESP_OK
                                                : ASC_RESP_ERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Latest sample, kept for software readback
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            value_r <= '0;
        end else if (disp_valid) begin
            value_r <= disp_value; // [RULE16]
        end
    end

    asc_tick #(.TICK_CYC(TICK_CYC)) u_tick (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .tick(tick)
    );

    // Independent channels
    for (genvar c = 0; c < NCH; c++) begin : g_ch // [RULE14]
        asc_chan u_ch (
            .clk_sys(clk_sys),
            .reset_n(reset_n),
            .value(disp_value),
            .sample(disp_valid),
            .tick(tick),
            .ack(ack_any),
            .hi(hi_r[c]),
            .lo(lo_r[c]),
            .hi_en(en_r[c][ASC_EN_HI]),
            .lo_en(en_r[c][ASC_EN_LO]),
            .db(db_r[c]),
            .dly(dly_r[c]),
            .alarm(alarm[c]),
            .acked(acked[c]),
            .cond(cond[c]),
            .trip_ev(trip_ev[c])
        );
    end

    // Flash phase; a shared blinker keeps lamps in step
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            fcnt_r <= '0;
            flash_r <= 1'b0;
        end else if (tick) begin
            fcnt_r <= (fcnt_r == 8'(FLASH_TICKS - 1)) ? '0 : fcnt_r + 1'b1;
            if (fcnt_r == 8'(FLASH_TICKS - 1)) begin
                flash_r <= !flash_r;
            end
        end
    end

    // Outputs, interrupt status; set wins over clear
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            relay_req <= '0;
            lamp_on <= '0;
            status_r <= '0;
            irq <= 1'b0;
        end else begin
            relay_req <= alarm; // [RULE10]
            lamp_on <= alarm & (acked | {NCH{flash_r}}); // [RULE12] [RULE13]
            status_r <= (status_r & ~w1c) | trip_ev;
            irq <= |(((status_r & ~w1c) | trip_ev) & mask_r);
        end
    end
endmodule // asc_top

// ---- bench/asc_top_sva.sv ----
// Checker: port-level assertions for the alarm comparator top
`timescale 1ns/1ns
module asc_top_sva
    import asc_pkg::*;
#(
    parameter int NCH = ASC_CHANNELS
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Sample strobe and alarm outputs
    input wire logic disp_valid,
    input wire logic [NCH-1:0] relay_req,
    input wire logic [NCH-1:0] lamp_on,
    input wire logic irq,
    // Register bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    // Conditions move only on samples, so a release follows one by 3 clocks
    a_clear_on_sample: assert property (
        |($past(relay_req) & ~relay_req) |-> $past(disp_valid, 3))
        else $error("relay released without a sample");
    // Skew of up to one clock either way between lamp and relay is tolerated
    a_lamp_in_alarm: assert property (
        ($past(lamp_on) & ~relay_req & ~$past(relay_req)
         & ~$past(relay_req, 2)) == '0)
        else $error("lamp lit with no alarm");
    // Register access used to set thresholds, deadband and delay
    a_read_latency: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_latency: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> ##1 s_axi_bvalid)
        else $error("write answer late");
    a_rdata_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped or changed");
    a_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped or changed");
    a_bresp_done: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    a_ar_refused: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while answering");
    a_aw_refused: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answering");

    // Main scenarios reached
    c_relay_set: cover property (|(relay_req & ~$past(relay_req)));
    c_lamp_set: cover property (|(lamp_on & ~$past(lamp_on)));
    c_irq_set: cover property ($rose(irq));
endmodule // asc_top_sva

bind asc_top asc_top_sva #(.NCH(NCH)) u_sva (.clk_sys, .reset_n,
    .disp_valid, .relay_req, .lamp_on, .irq, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready);

// ---- bench/asc_panel_model.sv ----
// Front panel model: acknowledge sources and one lamp watcher
`timescale 1ns/1ns
module asc_panel_model
    import asc_pkg::*;
#(
    parameter int NCH = ASC_CHANNELS,
    parameter int WATCH = 5
) (
    // Clock
    input wire logic clk_sys,
    // Lamps under observation
    input wire logic [NCH-1:0] lamp_on,
    // Acknowledge sources
    output logic ack_button,
    output logic ack_remote,
    // Turn-on edges seen on the watched lamp
    output logic [7:0] rises
);
    logic lamp_d;

    initial begin
        ack_button = 1'b0;
        ack_remote = 1'b0;
        lamp_d = 1'b0;
        rises = 8'h00;
    end

    // Edge counter: a steady lamp adds nothing
    always @(posedge clk_sys) begin
        lamp_d <= lamp_on[WATCH];
        if (lamp_on[WATCH] && !lamp_d) begin
            rises <= rises + 8'h01;
        end
    end

    // One-clock press of the button or the remote contact
    task automatic press(input bit remote);
        @(posedge clk_sys);
        ack_button <= !remote;
        ack_remote <= remote;
        @(posedge clk_sys);
        ack_button <= 1'b0;
        ack_remote <= 1'b0;
    endtask
endmodule // asc_panel_model

// ---- bench/tb_alarm_setpoint_comparator.sv ----
// Testbench: registers, threshold modes, trip delay and annunciator
`timescale 1ns/1ns
module tb_alarm_setpoint_comparator
    import asc_pkg::*;
;
    logic clk_sys, reset_n, disp_valid, ack_button, ack_remote, irq;
    logic [31:0] disp_value, s_axi_wdata, s_axi_rdata, rd;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [7:0] relay_req, lamp_on, rises, r0;
    int err_total, samples_checked, cyc;
    // Per channel: max, min, enable, deadband, delay
    logic [31:0] cfg [6][5] = '{
        '{32'h64, 32'h0, 32'h1, 32'hA, 32'h0},
        '{32'h0, 32'hFFFFFFEC, 32'h2, 32'h5, 32'h0},
        '{32'h32, 32'hA, 32'h3, 32'h0, 32'h0},
        '{32'hA, 32'h32, 32'h3, 32'h0, 32'h0},
        '{32'h0, 32'h0, 32'h0, 32'hA, 32'h0},
        '{32'h3E8, 32'h0, 32'h1, 32'hA, 32'h3}};
    logic [31:0] vals [10] = '{32'h1E, 32'h63, 32'h64, 32'h5A, 32'h59,
        32'hFFFFFFEC, 32'hFFFFFFF1, 32'hFFFFFFF2, 32'h1E, 32'h0};
    logic [7:0] expv [10] = '{8'h08, 8'h04, 8'h05, 8'h05, 8'h04, 8'h06,
        8'h06, 8'h04, 8'h08, 8'h04};

    // Short tick and flash so the run stays brief
    asc_top #(.TICK_CYC(20), .FLASH_TICKS(2)) DUT (.clk_sys, .reset_n,
        .disp_value, .disp_valid, .ack_button, .ack_remote, .relay_req,
        .lamp_on, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    asc_panel_model #(.WATCH(5)) u_panel (.clk_sys, .lamp_on, .ack_button,
        .ack_remote, .rises);

    always #25 clk_sys = ~clk_sys;

    function automatic logic [11:0] cha(input int c, input int r);
        return ASC_A_CH_BASE + 12'((c << ASC_CH_SHIFT) + r * 4);
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic final_report();
        if (err_total == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Handshakes judged mid-cycle: outputs move only on rising edges
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [2:0] p, t;
        p = 3'b111;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (p[0]) begin
            @(negedge clk_sys);
            t = p & {s_axi_awready, s_axi_wready, s_axi_bvalid};
            rs = s_axi_bresp;
            @(posedge clk_sys);
            if (t[2]) s_axi_awvalid <= 1'b0;
            if (t[1]) s_axi_wvalid <= 1'b0;
            if (t[0]) s_axi_bready <= 1'b0;
            p = p & ~t;
        end
    endtask

    task automatic rd_reg(input logic [11:0] a);
        logic [1:0] p, t;
        p = 2'b11;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (p[0]) begin
            @(negedge clk_sys);
            t = p & {s_axi_arready, s_axi_rvalid};
            rd = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge clk_sys);
            if (t[1]) s_axi_arvalid <= 1'b0;
            if (t[0]) s_axi_rready <= 1'b0;
            p = p & ~t;
        end
    endtask

    // One sample strobe, then settle past the 3-clock output latency
    task automatic smp(input logic [31:0] v);
        @(posedge clk_sys);
        disp_value <= v;
        disp_valid <= 1'b1;
        @(posedge clk_sys);
        disp_valid <= 1'b0;
        disp_value <= ~v; // Released value scrambled
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    // Hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            final_report();
        end
    end

    initial begin
        clk_sys = 1'b0;
        reset_n = 1'b0;
        disp_valid = 1'b0;
        disp_value = 32'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        s_axi_awaddr = 12'h0;
        s_axi_araddr = 12'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        err_total = 0;
        samples_checked = 0;
        cyc = 0;
        repeat (8) @(posedge clk_sys);
        reset_n <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            rd_reg(cha(c, ASC_R_EN));
            chk("enable", rd, 32'h0);
            rd_reg(cha(c, ASC_R_DB));
            chk("deadband", rd, {16'h0, ASC_DB_RST});
            rd_reg(cha(c, ASC_R_DLY));
            chk("delay", rd, {16'h0, ASC_DLY_RST});
        end
        rd_reg(12'h020);
        chk("unmapped", {rd[31:2], rs}, {30'h0, ASC_RESP_ERR});
        wr(12'h020, 32'h0);
        chk("bresp err", {30'h0, rs}, {30'h0, ASC_RESP_ERR});
        wr(cha(7, ASC_R_DB), 32'hFFFF);
        chk("bresp ok", {30'h0, rs}, {30'h0, ASC_RESP_OK});
        rd_reg(cha(7, ASC_R_DB));
        chk("db clamp", rd, {16'h0, ASC_DB_MAX});
        wr(cha(7, ASC_R_DLY), 32'hFFFF);
        rd_reg(cha(7, ASC_R_DLY));
        chk("dly max", rd, 32'hFFFF);
        for (int c = 0; c < 6; c++) begin
            for (int r = 0; r < 5; r++) begin
                wr(cha(c, r), cfg[c][r]);
            end
        end
        wr(ASC_A_MASK, 32'h1);
        // Walk through upper, lower, band and overlap modes together
        for (int i = 0; i < 10; i++) begin
            smp(vals[i]);
            chk("relay", 32'(relay_req), 32'(expv[i]));
            chk("off ch", 32'(relay_req[4]), 32'h0);
            chk("bd", 32'(relay_req[3:2]), 32'(expv[i][3:2]));
            chk("hy", 32'(relay_req[1:0]), 32'(expv[i][1:0]));
            if (i == 0) chk("irq masked", {31'h0, irq}, 32'h0);
            if (i == 2) begin
                chk("irq", {31'h0, irq}, 32'h1);
                rd_reg(ASC_A_STATUS);
                chk("status", rd, 32'hD);
                rd_reg(ASC_A_VALUE);
                chk("value", rd, 32'h64);
                wr(ASC_A_STATUS, 32'h1);
                repeat (2) @(negedge clk_sys);
                chk("irq clear", {31'h0, irq}, 32'h0);
            end
        end
        // Interrupted condition must restart the three-tick delay
        smp(32'h3E8);
        repeat (30) @(negedge clk_sys);
        chk("early", {31'h0, relay_req[5]}, 32'h0);
        smp(32'h0);
        smp(32'h3E8);
        repeat (25) @(negedge clk_sys);
        chk("restart", {31'h0, relay_req[5]}, 32'h0);
        repeat (60) @(negedge clk_sys);
        chk("tripped", {31'h0, relay_req[5]}, 32'h1);
        smp(32'h0);
        // Flash, acknowledge from each source, steady, then clear
        for (int k = 0; k < 3; k++) begin
            smp(32'h3E8);
            r0 = rises;
            repeat (250) @(negedge clk_sys);
            chk("flash", {31'h0, (rises - r0) >= 8'h2}, 32'h1);
            if (k == 2) wr(ASC_A_ACK, 32'h1);
            else u_panel.press(k[0]);
            repeat (10) @(negedge clk_sys);
            r0 = rises;
            repeat (100) @(negedge clk_sys);
            chk("steady", {23'h0, rises - r0, lamp_on[5]}, 32'h1);
            rd_reg(ASC_A_ALARM);
            chk("acked", rd & 32'h2020, 32'h2020);
            smp(32'h0);
            chk("off", {30'h0, relay_req[5], lamp_on[5]}, 32'h0);
        end
        final_report();
    end
endmodule // tb_alarm_setpoint_comparator
